/* rtl/fast_image_dump.sv */
/*
 * Fast image dump framer: sends captured pixels out on the data and
 * interrupt pins, paced by the dump clock on the general-purpose pin.
 * Assumes register writes arrive as a one-cycle strobe on clk, and that
 * the pixel source pushes pixels in the address order it is told.
 */
`timescale 1ns/10ps
module fast_image_dump #(
    parameter int unsigned BURST_PERIOD = dump_pkg::BURST_PERIOD_CYC,
    parameter int unsigned FIFO_DEPTH   = dump_pkg::FIFO_DEPTH
) (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire dump_pkg::reg_wr_s             reg_wr,
    input  wire logic                          dump_clk_pin,
    input  wire logic                          pix_valid,
    input  wire logic [dump_pkg::PIX_W-1:0]    pix_data,
    output logic                               pix_ready,
    output logic [8:0]                         pix_addr,
    output dump_pkg::dump_pins_s               pins_o,
    output dump_pkg::dump_pins_s               pins_oe,
    output logic                               three_wire,
    output logic                               busy,
    output logic                               underrun
);
    localparam logic [8:0] LAST_PIX   = 9'(dump_pkg::PIXELS - 1);
    localparam logic [1:0] LAST_FRAME = 2'(dump_pkg::FRAMES - 1);
    localparam logic [6:0] LAST_BURST = 7'(dump_pkg::BURSTS - 1);
    localparam logic [1:0] LAST_SOF   = 2'(dump_pkg::SOF_CYCLES - 1);
    localparam logic [1:0] LAST_DATA  = 2'(dump_pkg::DATA_CYCLES - 1);
    localparam int unsigned GW = $clog2(BURST_PERIOD + 1);
    localparam logic [GW-1:0] LAST_GAP = GW'(BURST_PERIOD - 1);

    ////////////////////////////////////////////////////////////////////
    // Dump clock pin sampling and edge finding

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic tick;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= dump_clk_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Rising edge of the dump clock; host samples on the falling one
    assign tick = sync2_r && !sync3_r;

    ////////////////////////////////////////////////////////////////////
    // Setup sequence tracking and mode

    logic       soft_rst;
    logic       go_wr;
    logic [2:0] setup_r;
    logic [2:0] setup_nxt;
    logic       three_r;
    logic       three_nxt;

    function automatic logic step_match(input logic [2:0] step,
                                        input dump_pkg::reg_wr_s wr);
        unique case (step)
            3'h1: step_match = wr.addr == dump_pkg::REG_SETUP1 &&
                               wr.data == dump_pkg::VAL_SETUP1;
            3'h2: step_match = wr.addr == dump_pkg::REG_SETUP2 &&
                               wr.data == dump_pkg::VAL_SETUP2;
            3'h3: step_match = wr.addr == dump_pkg::REG_SETUP3 &&
                               wr.data == dump_pkg::VAL_SETUP3;
            3'h4: step_match = wr.addr == dump_pkg::REG_SETUP4 &&
                               wr.data == dump_pkg::VAL_SETUP4;
            default: step_match = 1'b0;
        endcase
    endfunction : step_match

    assign soft_rst = reg_wr.valid && reg_wr.addr == dump_pkg::REG_SOFT_RESET &&
                      reg_wr.data == dump_pkg::VAL_SOFT_RESET;
    assign go_wr    = reg_wr.valid && reg_wr.addr == dump_pkg::REG_DUMP_GO &&
                      reg_wr.data == dump_pkg::VAL_DUMP_GO;

    dump_pkg::dump_state_e st_r;
    dump_pkg::dump_state_e st_nxt;
    logic                  start;

    // Start only from idle with the whole setup sequence seen
    assign start = go_wr && setup_r == dump_pkg::SETUP_DONE &&
                   st_r == dump_pkg::ST_IDLE;

    always_comb begin
        setup_nxt = setup_r;
        three_nxt = three_r;
        if (soft_rst) begin
            setup_nxt = 3'h1;
            three_nxt = 1'b0;
        end else if (start) begin
            setup_nxt = 3'h0;
            three_nxt = 1'b1;
        end else if (reg_wr.valid && step_match(setup_r, reg_wr)) begin
            setup_nxt = setup_r + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            setup_r <= 3'h0;
            three_r <= 1'b0;
        end else begin
            setup_r <= setup_nxt;
            three_r <= three_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pixel buffer and source addressing

    logic                       fifo_ready;
    logic                       fifo_valid;
    logic [dump_pkg::PIX_W-1:0] fifo_data;
    logic                       pop;
    logic [8:0]                 src_r;
    logic [8:0]                 src_nxt;

    dump_fifo #(
        .WIDTH (dump_pkg::PIX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (pix_valid && three_r),
        .in_data   (pix_data),
        .in_ready  (fifo_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop)
    );

    // Source is asked for pixels row by row, left to right
    always_comb begin
        src_nxt = src_r;
        if (soft_rst || start) begin
            src_nxt = 9'h0;
        end else if (pix_valid && pix_ready && three_r) begin
            src_nxt = (src_r == LAST_PIX) ? 9'h0 : src_r + 9'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_r <= 9'h0;
        end else begin
            src_r <= src_nxt;
        end
    end

    // Ready only while a push is really taken, so the source never loses a pixel
    assign pix_ready = fifo_ready && three_r;
    assign pix_addr  = src_r;

    ////////////////////////////////////////////////////////////////////
    // Framing state machine

    logic [1:0]                 sub_r, sub_nxt;
    logic [8:0]                 pix_r, pix_nxt;
    logic [1:0]                 frm_r, frm_nxt;
    logic [6:0]                 bst_r, bst_nxt;
    logic [GW-1:0]              gap_r, gap_nxt;
    logic [dump_pkg::PIX_W-1:0] shf_r, shf_nxt;
    logic [1:0]                 sym_r, sym_nxt;
    logic                       und_r, und_nxt;

    assign pop = tick && st_r == dump_pkg::ST_PBEG && fifo_valid && !soft_rst;

    always_comb begin
        st_nxt  = st_r;
        sub_nxt = sub_r;
        pix_nxt = pix_r;
        frm_nxt = frm_r;
        bst_nxt = bst_r;
        shf_nxt = shf_r;
        sym_nxt = sym_r;
        und_nxt = und_r;
        // Burst period timer runs through bursts and gaps alike
        gap_nxt = (gap_r == LAST_GAP) ? '0 : gap_r + 1'b1;
        if (st_r == dump_pkg::ST_IDLE || st_r == dump_pkg::ST_DONE) begin
            gap_nxt = '0;
        end
        if (soft_rst) begin
            st_nxt  = dump_pkg::ST_IDLE;
            sym_nxt = dump_pkg::SYM_EOF;
            und_nxt = 1'b0;
        end else if (start) begin
            st_nxt  = dump_pkg::ST_SOF;
            sub_nxt = 2'h0;
            pix_nxt = 9'h0;
            frm_nxt = 2'h0;
            bst_nxt = 7'h0;
            gap_nxt = '0;
            und_nxt = 1'b0;
        end else if (st_r == dump_pkg::ST_GAP) begin
            if (gap_r == LAST_GAP) begin
                st_nxt = dump_pkg::ST_SOF;
            end
        end else if (tick) begin
            unique case (st_r)
                dump_pkg::ST_SOF: begin
                    sym_nxt = dump_pkg::SYM_SOF;
                    sub_nxt = sub_r + 2'h1;
                    if (sub_r == LAST_SOF) begin
                        st_nxt  = dump_pkg::ST_PBEG;
                        sub_nxt = 2'h0;
                    end
                end
                dump_pkg::ST_PBEG: begin
                    sym_nxt = dump_pkg::SYM_PBEG;
                    shf_nxt = fifo_valid ? fifo_data : '0;
                    und_nxt = und_r || !fifo_valid;
                    st_nxt  = dump_pkg::ST_PDAT;
                end
                dump_pkg::ST_PDAT: begin
                    // Both nibbles leave MSB first, one bit of each per cycle
                    sym_nxt = {shf_r[7], shf_r[3]};
                    shf_nxt = {shf_r[6:4], 1'b0, shf_r[2:0], 1'b0};
                    sub_nxt = sub_r + 2'h1;
                    if (sub_r == LAST_DATA) begin
                        st_nxt  = dump_pkg::ST_PEND;
                        sub_nxt = 2'h0;
                    end
                end
                dump_pkg::ST_PEND: begin
                    sym_nxt = dump_pkg::SYM_PEND;
                    if (pix_r == LAST_PIX) begin
                        st_nxt = dump_pkg::ST_EOF;
                    end else begin
                        pix_nxt = pix_r + 9'h1;
                        st_nxt  = dump_pkg::ST_PBEG;
                    end
                end
                dump_pkg::ST_EOF: begin
                    sym_nxt = dump_pkg::SYM_EOF;
                    pix_nxt = 9'h0;
                    if (frm_r != LAST_FRAME) begin
                        frm_nxt = frm_r + 2'h1;
                        st_nxt  = dump_pkg::ST_SOF;
                    end else if (bst_r != LAST_BURST) begin
                        frm_nxt = 2'h0;
                        bst_nxt = bst_r + 7'h1;
                        st_nxt  = dump_pkg::ST_GAP;
                    end else begin
                        st_nxt = dump_pkg::ST_DONE;
                    end
                end
                default: begin
                    sym_nxt = sym_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r  <= dump_pkg::ST_IDLE;
            sub_r <= 2'h0;
            pix_r <= 9'h0;
            frm_r <= 2'h0;
            bst_r <= 7'h0;
            gap_r <= '0;
            shf_r <= '0;
            sym_r <= dump_pkg::SYM_EOF;
            und_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            sub_r <= sub_nxt;
            pix_r <= pix_nxt;
            frm_r <= frm_nxt;
            bst_r <= bst_nxt;
            gap_r <= gap_nxt;
            shf_r <= shf_nxt;
            sym_r <= sym_nxt;
            und_r <= und_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drive

    assign pins_o.sdo  = sym_r[1];
    assign pins_o.irq  = sym_r[0];
    assign pins_oe.sdo = three_r;
    assign pins_oe.irq = three_r;
    assign three_wire  = three_r;
    assign busy        = st_r != dump_pkg::ST_IDLE && st_r != dump_pkg::ST_DONE;
    assign underrun    = und_r;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sof_symbol_a: assert property (
        tick && st_r == dump_pkg::ST_SOF && !soft_rst |=> pins_o.sdo && pins_o.irq)
        else $error("frame start symbol wrong");

    sof_length_a: assert property (
        tick && st_r == dump_pkg::ST_SOF && sub_r == LAST_SOF && !soft_rst
        |=> st_r == dump_pkg::ST_PBEG && $past(sub_r) == 2'h3)
        else $error("frame start not four cycles");

    pix_begin_a: assert property (
        tick && st_r == dump_pkg::ST_PBEG && !soft_rst
        |=> !pins_o.sdo && pins_o.irq ##0 st_r == dump_pkg::ST_PDAT)
        else $error("pixel begin symbol wrong");

    pix_bits_a: assert property (
        tick && st_r == dump_pkg::ST_PDAT && !soft_rst
        |=> pins_o.sdo == $past(shf_r[7]) && pins_o.irq == $past(shf_r[3]))
        else $error("pixel bit order wrong");

    pix_end_a: assert property (
        tick && st_r == dump_pkg::ST_PEND && !soft_rst |=> pins_o.sdo && !pins_o.irq)
        else $error("pixel end symbol wrong");

    pix_order_a: assert property (
        tick && st_r == dump_pkg::ST_PEND && pix_r != LAST_PIX && !soft_rst
        |=> pix_r == $past(pix_r) + 9'h1)
        else $error("pixel address skipped");

    frame_end_a: assert property (
        tick && st_r == dump_pkg::ST_PEND && pix_r == LAST_PIX && !soft_rst
        |=> st_r == dump_pkg::ST_EOF)
        else $error("frame end missing");

    eof_symbol_a: assert property (
        tick && st_r == dump_pkg::ST_EOF && !soft_rst |=> !pins_o.sdo && !pins_o.irq)
        else $error("frame end symbol wrong");

    burst_count_a: assert property (
        $rose(st_r == dump_pkg::ST_DONE) |-> $past(bst_r) == LAST_BURST &&
        $past(frm_r) == LAST_FRAME)
        else $error("wrong burst or frame count");

    start_go_a: assert property (
        start && !soft_rst |=> st_r == dump_pkg::ST_SOF && three_wire)
        else $error("dump did not start");

    soft_reset_a: assert property (
        soft_rst |=> st_r == dump_pkg::ST_IDLE && !three_wire && !pins_oe.sdo)
        else $error("soft reset did not restore mode");

    start_cv: cover property (start);
    frame_end_cv: cover property (tick && st_r == dump_pkg::ST_EOF);
    done_cv: cover property ($rose(st_r == dump_pkg::ST_DONE));
    underrun_cv: cover property ($rose(und_r));

endmodule : fast_image_dump

/* rtl/dump_pkg.sv */
/*
 * Shared constants and types of the fast image dump framer.
 * Assumes a 100 MHz system clock and a register write strobe from the
 * serial port logic on that clock.
 */
package dump_pkg;

    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned DUMP_CLK_MAX_MHZ = 24;
    localparam int unsigned DUMP_MS         = 500;
    localparam int unsigned BURSTS          = 64;
    localparam int unsigned FRAMES          = 3;
    localparam int unsigned PIXELS          = 361;
    localparam int unsigned ROW_LEN         = 19;
    localparam int unsigned SOF_CYCLES      = 4;
    localparam int unsigned DATA_CYCLES     = 4;
    localparam int unsigned PIX_W           = 8;
    localparam int unsigned FIFO_DEPTH      = 4;
    // Burst spacing so that all bursts together take the dump time
    localparam int unsigned BURST_PERIOD_CYC = DUMP_MS * 1000 * CLK_MHZ / BURSTS;

    localparam logic [6:0] REG_SOFT_RESET = 7'h3a;
    localparam logic [7:0] VAL_SOFT_RESET = 8'h5a;
    localparam logic [6:0] REG_DUMP_GO    = 7'h28;
    localparam logic [7:0] VAL_DUMP_GO    = 8'h01;
    localparam logic [6:0] REG_SETUP1     = 7'h11;
    localparam logic [7:0] VAL_SETUP1     = 8'h53;
    localparam logic [6:0] REG_SETUP2     = 7'h30;
    localparam logic [7:0] VAL_SETUP2     = 8'h13;
    localparam logic [6:0] REG_SETUP3     = 7'h2b;
    localparam logic [7:0] VAL_SETUP3     = 8'h30;
    localparam logic [6:0] REG_SETUP4     = 7'h2c;
    localparam logic [7:0] VAL_SETUP4     = 8'h13;
    localparam logic [2:0] SETUP_DONE     = 3'h5;

    // Pin symbols, {data pin, interrupt pin}
    localparam logic [1:0] SYM_SOF  = 2'h3;
    localparam logic [1:0] SYM_PBEG = 2'h1;
    localparam logic [1:0] SYM_PEND = 2'h2;
    localparam logic [1:0] SYM_EOF  = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SOF, ST_PBEG, ST_PDAT, ST_PEND, ST_EOF, ST_GAP, ST_DONE
    } dump_state_e;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_wr_s;

    typedef struct packed {
        logic sdo;
        logic irq;
    } dump_pins_s;

endpackage : dump_pkg

/* rtl/dump_fifo.sv */
/*
 * Small flop-based FIFO with valid/ready on both sides.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/10ps
module dump_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW:0]      wr_r, wr_nxt;
    logic [AW:0]      rd_r, rd_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_r - rd_r) != (AW + 1)'(DEPTH);
    assign out_valid = wr_r != rd_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_r[AW-1:0]];

    always_comb begin
        mem_nxt = mem_r;
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        if (push) begin
            mem_nxt[wr_r[AW-1:0]] = in_data;
            wr_nxt = (wr_r[AW-1:0] == AW'(DEPTH - 1)) ?
                     {~wr_r[AW], {AW{1'b0}}} : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r[AW-1:0] == AW'(DEPTH - 1)) ?
                     {~rd_r[AW], {AW{1'b0}}} : rd_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
        end
    end

endmodule : dump_fifo

/* tb/host_capture.sv */
/*
 * Host capture model: makes the dump clock and decodes the pin symbols.
 * Assumes the pins change after the rising dump clock edge.
 */
`timescale 1ns/10ps
module host_capture (
    input  wire logic                 run,
    input  wire logic                 clear,
    input  wire dump_pkg::dump_pins_s pins,
    output logic                      dump_clk,
    output logic [7:0]                last_byte,
    output int                        pix_seen,
    output int                        frame_seen,
    output int                        sym_errs
);
    int         st;
    int         cnt;
    int         in_frame;
    logic [7:0] b;
    logic [1:0] sym;

    ////////////////////////////////////////////////////////////////////////////
    // Still while not running; 125 ns period
    initial begin
        dump_clk = 1'b0;
        forever begin
            #62.5;
            dump_clk = run ? ~dump_clk : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sampled on the falling edge, half a period after the rising edge that moves the pins
    always @(negedge dump_clk or posedge clear) begin
        sym = {pins.sdo, pins.irq};
        if (clear) begin
            st = 0;
            cnt = 0;
            in_frame = 0;
            pix_seen = 0;
            frame_seen = 0;
            sym_errs = 0;
        end else begin
            case (st)
                0: if (sym == 2'b11) begin
                    st = 1;
                    cnt = 1;
                end else if (frame_seen % dump_pkg::FRAMES != 0) sym_errs++;
                1: if (sym == 2'b11 && cnt < dump_pkg::SOF_CYCLES) cnt++;
                else if (sym == 2'b01 && cnt == dump_pkg::SOF_CYCLES) begin
                    st = 2;
                    cnt = 0;
                end else sym_errs++;
                2: begin
                    b[7-cnt] = sym[1];
                    b[3-cnt] = sym[0];
                    cnt++;
                    if (cnt == dump_pkg::DATA_CYCLES) st = 3;
                end
                3: if (sym == 2'b10) begin
                    last_byte = b;
                    in_frame++;
                    pix_seen++;
                    st = 4;
                end else sym_errs++;
                default: if (sym == 2'b01 && in_frame < dump_pkg::PIXELS) begin
                    st = 2;
                    cnt = 0;
                end else if (sym == 2'b00 && in_frame == dump_pkg::PIXELS) begin
                    frame_seen++;
                    in_frame = 0;
                    st = 0;
                end else sym_errs++;
            endcase
        end
    end
endmodule : host_capture

/* tb/fast_image_dump_framer_tb.sv */
/*
 * Testbench of the fast image dump framer: register writes, pixel source,
 * host capture model and the checks.
 * Assumes the design package and the host capture model are compiled first.
 */
`timescale 1ns/10ps
module fast_image_dump_framer_tb;
    localparam int PIX = dump_pkg::PIXELS;
    localparam int PER_BURST = dump_pkg::FRAMES * PIX;

    logic                 clk, arst_n, pix_valid, pix_ready, three_wire, busy, underrun;
    logic                 run, clear, dclk, feed, chk_bytes;
    logic [7:0]           pix_data, last_byte;
    logic [8:0]           pix_addr;
    dump_pkg::reg_wr_s    reg_wr;
    dump_pkg::dump_pins_s pins_o, pins_oe;
    int                   pix_seen, frame_seen, sym_errs, src_idx, failures, check_count;

    fast_image_dump #(.BURST_PERIOD(200000), .FIFO_DEPTH(dump_pkg::FIFO_DEPTH)) dut (
        .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .dump_clk_pin(dclk),
        .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
        .pix_addr(pix_addr), .pins_o(pins_o), .pins_oe(pins_oe),
        .three_wire(three_wire), .busy(busy), .underrun(underrun));

    host_capture host (.run(run), .clear(clear), .pins(pins_o), .dump_clk(dclk),
        .last_byte(last_byte), .pix_seen(pix_seen), .frame_seen(frame_seen),
        .sym_errs(sym_errs));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 17);
    endfunction : pat

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= '{valid: 1'b1, addr: a, data: d};
        @(posedge clk);
        reg_wr <= '0;
    endtask : wr

    task automatic setup;
        wr(dump_pkg::REG_SETUP1, dump_pkg::VAL_SETUP1);
        wr(dump_pkg::REG_SETUP2, dump_pkg::VAL_SETUP2);
        wr(dump_pkg::REG_SETUP3, dump_pkg::VAL_SETUP3);
        wr(dump_pkg::REG_SETUP4, dump_pkg::VAL_SETUP4);
    endtask : setup

    ////////////////////////////////////////////////////////////////////////////
    // Pixel source in address order, and the byte check against it
    always @(posedge clk) begin
        if (pix_valid && pix_ready) begin
            chk("pixel address", 32'(src_idx % PIX), 32'(pix_addr));
            src_idx++;
            pix_data <= pat(src_idx % PIX);
        end
        pix_valid <= feed && src_idx < PER_BURST;
    end

    always @(pix_seen) if (chk_bytes && pix_seen > 0)
        chk("pixel byte", 32'(pat((pix_seen - 1) % PIX)), 32'(last_byte));

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_refused;
        #1 chk("reset outputs", 0,
            {pins_o, pins_oe, three_wire, busy, underrun, pix_ready, pix_addr});
        wr(dump_pkg::REG_SOFT_RESET, dump_pkg::VAL_SOFT_RESET);
        wr(dump_pkg::REG_DUMP_GO, dump_pkg::VAL_DUMP_GO);
        #1 chk("start without setup", 0, {three_wire, busy});
    endtask : t_refused

    task automatic t_start_fill;
        feed = 1'b1;
        run = 1'b1;
        setup();
        wr(dump_pkg::REG_DUMP_GO, dump_pkg::VAL_DUMP_GO);
        #1 chk("start", 32'h0000_000f, {three_wire, pins_oe, busy});
        repeat (10) @(posedge clk);
        #1 chk("fifo full", 32'h0000_0004, {pix_ready, pix_addr});
    endtask : t_start_fill

    task automatic t_burst;
        for (int i = 0; i < 20000 && pix_seen < 100; i++) @(posedge clk);
        feed = 1'b0;
        repeat (150) @(posedge clk);
        feed = 1'b1;
        for (int i = 0; i < 90000 && frame_seen < 3; i++) @(posedge clk);
        repeat (30) @(posedge dclk);
        #1 chk("frames per burst", 3, frame_seen);
        chk("pixels per burst", PER_BURST, pix_seen);
        chk("symbol errors", 0, sym_errs);
        chk("idle pins, underrun", 0, {pins_o, underrun});
        chk("three wire held", 1, three_wire);
        wr(dump_pkg::REG_SOFT_RESET, dump_pkg::VAL_SOFT_RESET);
        #1 chk("soft reset", 0, {three_wire, busy, pins_o, pins_oe, pix_ready});
    endtask : t_burst

    task automatic t_underrun;
        feed = 1'b0;
        chk_bytes = 1'b0;
        clear = 1'b1;
        #1 clear = 1'b0;
        setup();
        wr(dump_pkg::REG_DUMP_GO, dump_pkg::VAL_DUMP_GO);
        for (int i = 0; i < 300 && underrun !== 1'b1; i++) @(posedge clk);
        #1 chk("underrun", 1, underrun);
        wr(dump_pkg::REG_SOFT_RESET, dump_pkg::VAL_SOFT_RESET);
        #1 chk("underrun cleared", 0, {underrun, three_wire, pins_oe});
    endtask : t_underrun

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("unexpected watchdog: expected done, seen still running");
        print_verdict();
    end

    initial begin
        arst_n = 1'b0;
        reg_wr = '0;
        pix_valid = 1'b0;
        pix_data = pat(0);
        {run, clear, feed} = 3'h0;
        chk_bytes = 1'b1;
        {src_idx, failures, check_count} = '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_refused();
        t_start_fill();
        t_burst();
        t_underrun();
        print_verdict();
    end
endmodule : fast_image_dump_framer_tb
